/* verilog/bus_strobe_pkg.sv */
/*
  Constants and types shared by the external bus strobe sequencer and its
  address/data pin driver. Assumes a single 250 MHz clock domain.
*/
package bus_strobe_pkg;

  localparam int unsigned CLOCK_MHZ        = 250;
  localparam int unsigned ADDR_WIDTH       = 16;
  localparam int unsigned BYTE_WIDTH       = 8;
  // phase lengths in clock cycles
  localparam int unsigned ADDR_PHASE_CYCLES = 2;
  localparam int unsigned HOLD_CYCLES       = 1;
  localparam int unsigned DATA_PHASE_CYCLES = 4;
  localparam int unsigned COUNT_WIDTH       = 4;
  // chip_config_reg bit positions
  localparam int unsigned CFG_BIT_LATCH_MODE = 3;
  localparam int unsigned CFG_BIT_SIZE_EN    = 1;
  localparam logic [7:0]  CFG_RESET          = 8'h0A;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_HOLD,
    ST_DATA,
    ST_DONE
  } phase_type;

  typedef enum logic [1:0] {
    KIND_INSTR,
    KIND_DATA,
    KIND_CONFIG,
    KIND_VECTOR
  } access_kind_type;

endpackage

/* verilog/pin_drive_if.sv */
/*
  Carrier between the strobe sequencer and the address/data pin driver.
  Assumes both ends share the sequencer clock.
*/
interface pin_drive_if;
  import bus_strobe_pkg::*;

  logic                  addr_drive;
  logic                  data_drive;
  logic                  wide;
  logic [ADDR_WIDTH-1:0] addr;
  logic [ADDR_WIDTH-1:0] wdata;
  logic                  write;

  modport seq (output addr_drive, output data_drive, output wide, output addr, output wdata, output write);
  modport drv (input addr_drive, input data_drive, input wide, input addr, input wdata, input write);
endinterface

/* verilog/ad_pin_driver.sv */
/*
  Drives the multiplexed address/data lines from the sequencer's phase.
  Assumes the enclosing module registers nothing further on these outputs.
*/
module ad_pin_driver
  import bus_strobe_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  clock_enable,
  pin_drive_if.drv                   ctl,
  output logic      [ADDR_WIDTH-1:0] ad_out,
  output logic      [ADDR_WIDTH-1:0] ad_oe_n
);

  typedef struct packed {
    logic [ADDR_WIDTH-1:0] ad_out;
    logic [ADDR_WIDTH-1:0] ad_oe_n;
  } drive_state_type;

  drive_state_type state_q;
  drive_state_type state_d;

  // upper byte stays an address output in narrow cycles
  always_comb begin
    state_d = state_q;
    state_d.ad_oe_n = '1;
    if (ctl.addr_drive) begin
      state_d.ad_out  = ctl.addr;
      state_d.ad_oe_n = '0;
    end else if (ctl.data_drive) begin
      state_d.ad_out[ADDR_WIDTH-1:BYTE_WIDTH] = ctl.wide ? ctl.wdata[ADDR_WIDTH-1:BYTE_WIDTH]
                                                         : ctl.addr[ADDR_WIDTH-1:BYTE_WIDTH]; // [R8]
      state_d.ad_out[BYTE_WIDTH-1:0] = ctl.wdata[BYTE_WIDTH-1:0];
      state_d.ad_oe_n[ADDR_WIDTH-1:BYTE_WIDTH] = ctl.wide ? {BYTE_WIDTH{~ctl.write}} : '0; // [R8]
      state_d.ad_oe_n[BYTE_WIDTH-1:0] = {BYTE_WIDTH{~ctl.write}};
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= '{ad_out: '0, ad_oe_n: '1};
    end else if (clock_enable) begin
      state_q <= state_d;
    end
  end

  assign ad_out  = state_q.ad_out;
  assign ad_oe_n = state_q.ad_oe_n;

endmodule

/* verilog/bus_strobe_seq.sv */
/*
  External bus cycle sequencer: read strobe, shared latch/valid strobe and
  fetch-kind indicator, plus pin driving via ad_pin_driver.
  Assumes requests come from core logic on the same clock; the bus size
  input and the address/data lines read back come from pins and pass two
  flip-flops here. An external access runs address, hold and data phases
  and answers with a one-cycle done pulse; a request must stand until it
  is taken with ready high, and ready stays low in the first cycle after
  reset.
*/
// Functional notes
// [R1] read strobe low only on external reads
// [R2] latch strobe marks cycle start, valid address
// [R3] external latch captures address on strobe
// [R4] config bit picks latch or valid strobe
// [R5] valid strobe held until cycle completes
// [R6] fetch kind high instruction, low data
// [R7] config bytes and vectors count as data
// [R8] narrow cycles: upper lines dedicated address
// [R9] enabled size pin picks wide or narrow
// [R10] drop latch strobe before data phase
module bus_strobe_seq
  import bus_strobe_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  clock_enable,
  input  wire logic [7:0]            chip_config_reg,
  input  wire logic                  bus_size_select,
  input  wire logic                  req_valid,
  input  wire logic                  req_write,
  input  wire logic                  req_external,
  input  wire access_kind_type       req_kind,
  input  wire logic [ADDR_WIDTH-1:0] req_addr,
  input  wire logic [ADDR_WIDTH-1:0] req_wdata,
  input  wire logic [ADDR_WIDTH-1:0] ad_in,
  output logic                       req_ready,
  output logic                       done,
  output logic      [ADDR_WIDTH-1:0] rdata,
  output logic      [ADDR_WIDTH-1:0] muxed_addr_data_lines,
  output logic      [ADDR_WIDTH-1:0] muxed_addr_data_oe_n,
  output logic                       read_strobe_n,
  output logic                       address_valid_strobe,
  output logic                       fetch_kind
);

  // one record holds every flop of the sequencer
  typedef struct packed {
    phase_type              phase;      // where the cycle stands
    logic [COUNT_WIDTH-1:0] count;      // cycles left in this phase, minus one
    logic                   write;
    logic                   wide;       // 16-bit cycle, fixed at take
    logic                   latch_mode; // strobe function, fixed at take
    logic [ADDR_WIDTH-1:0]  addr;
    logic [ADDR_WIDTH-1:0]  wdata;
    logic [ADDR_WIDTH-1:0]  rdata;
    logic                   done;
    logic                   ready;
    logic                   rd_n;
    logic                   strobe;
    logic                   kind;
    logic                   size_meta;
    logic                   size_sync;
    logic [ADDR_WIDTH-1:0]  ad_meta;
    logic [ADDR_WIDTH-1:0]  ad_sync;
  } seq_state_type;

  // registered state and the copy that the combinational process fills
  seq_state_type state_q;
  seq_state_type state_d;

  // control bundle towards the pin driver
  pin_drive_if pins ();

  // phases load length minus one so that zero marks the last cycle
  function automatic logic [COUNT_WIDTH-1:0] cycles(input int unsigned n);
    cycles = COUNT_WIDTH'(n - 1);
  endfunction

  // last cycle of a counted phase
  function automatic logic phase_over(input logic [COUNT_WIDTH-1:0] cnt);
    phase_over = (cnt == '0);
  endfunction

  // word handed to the core; a narrow cycle only carries the low byte
  function automatic logic [ADDR_WIDTH-1:0] read_word(input logic wide, input logic [ADDR_WIDTH-1:0] lines);
    read_word = wide ? lines : {{(ADDR_WIDTH-BYTE_WIDTH){1'b0}}, lines[BYTE_WIDTH-1:0]};
  endfunction

  // sequencing; internal accesses never touch the pins
  always_comb begin
    state_d           = state_q;
    // two-flop synchronisers for the pins
    state_d.size_meta = bus_size_select;
    state_d.size_sync = state_q.size_meta;
    // the lines lag two cycles; the read strobe stands long enough that the
    // sample still falls where the memory holds its data steady
    state_d.ad_meta   = ad_in;
    state_d.ad_sync   = state_q.ad_meta;
    // done is a pulse: cleared here, set only on the closing edge or when an internal access is taken
    state_d.done      = 1'b0;
    case (state_q.phase)
      // nothing is taken while ready is still low after reset
      ST_IDLE: begin
        state_d.ready = 1'b1;
        if (state_q.ready && req_valid && req_external) begin  // [R1]
          state_d.phase = ST_ADDR;
          state_d.ready = 1'b0;
          state_d.count = cycles(ADDR_PHASE_CYCLES);
          state_d.write = req_write;
          state_d.addr  = req_addr;
          state_d.wdata = req_wdata;
          state_d.latch_mode = chip_config_reg[CFG_BIT_LATCH_MODE]; // [R4]
          state_d.wide = chip_config_reg[CFG_BIT_SIZE_EN] & state_q.size_sync; // [R9]
          state_d.kind = (req_kind == KIND_INSTR) && !req_write; // [R6] [R7]
          state_d.strobe = 1'b1; // [R2] [R5]
        end else if (state_q.ready && req_valid) begin
          // internal access: answered at the next edge, pins untouched
          state_d.done = 1'b1;
        end
      end

      // address on the lines with the strobe high; the driver adds one cycle
      ST_ADDR: begin
        // the external latch captures while strobe is high
        if (phase_over(state_q.count)) begin
          state_d.phase = ST_HOLD;
          state_d.count = cycles(HOLD_CYCLES);
          if (state_q.latch_mode) state_d.strobe = 1'b0; // [R10] [R3]
        end else begin
          state_d.count = state_q.count - 1'b1;
        end
      end

      // one hold cycle between address and data; the address stays driven
      ST_HOLD: begin
        // address hold margin before the lines turn round
        if (phase_over(state_q.count)) begin
          state_d.phase = ST_DATA;
          state_d.count = cycles(DATA_PHASE_CYCLES);
          state_d.rd_n = state_q.write; // [R1]
        end else begin
          state_d.count = state_q.count - 1'b1;
        end
      end

      // data transfer; the synchronised lines are taken in its last cycle
      ST_DATA: begin
        if (phase_over(state_q.count)) begin
          state_d.phase = ST_DONE;
          state_d.rd_n = 1'b1;
          if (!state_q.write) state_d.rdata = read_word(state_q.wide, state_q.ad_sync);
        end else begin
          state_d.count = state_q.count - 1'b1;
        end
      end

      // cycle complete: the valid strobe and fetch kind drop with the done pulse,
      // so the far side never sees a strobe outside a bus cycle
      ST_DONE: begin
        state_d.strobe = 1'b0; // [R5]
        state_d.kind   = 1'b0;
        state_d.done   = 1'b1;
        state_d.ready  = 1'b1;
        state_d.phase  = ST_IDLE;
      end
      default: state_d.phase = ST_IDLE;
    endcase
  end

  // asynchronous reset; clock_enable low freezes every flop
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= '{phase:      ST_IDLE,
                   count:      '0,
                   write:      1'b0,
                   wide:       1'b0,
                   latch_mode: 1'b1,
                   addr:       '0,
                   wdata:      '0,
                   rdata:      '0,
                   done:       1'b0,
                   ready:      1'b0,
                   rd_n:       1'b1,
                   strobe:     1'b0,
                   kind:       1'b0,
                   size_meta:  1'b0,
                   size_sync:  1'b0,
                   ad_meta:    '0,
                   ad_sync:    '0};
    end else if (clock_enable) begin
      state_q <= state_d;
    end
  end

  // pin driver control; the driver registers these, so the lines trail the
  // phase by one cycle, which the strobe timing allows for
  assign pins.addr_drive = (state_q.phase == ST_ADDR) || (state_q.phase == ST_HOLD);
  assign pins.data_drive = (state_q.phase == ST_DATA);
  assign pins.wide       = state_q.wide;
  assign pins.addr       = state_q.addr;
  assign pins.wdata      = state_q.wdata;
  assign pins.write      = state_q.write;

  // pin flops live in the driver so the lines are registered like the strobes
  ad_pin_driver u_drv (
    .clock        (clock),
    .rst          (rst),
    .clock_enable (clock_enable),
    .ctl          (pins),
    .ad_out       (muxed_addr_data_lines),
    .ad_oe_n      (muxed_addr_data_oe_n)
  );

  // every output is a flop of the record or of the pin driver; nothing combinational reaches
  // the pins or the core
  assign req_ready            = state_q.ready;
  assign done                 = state_q.done;
  assign rdata                = state_q.rdata;
  assign read_strobe_n        = state_q.rd_n;
  assign address_valid_strobe = state_q.strobe;
  assign fetch_kind           = state_q.kind;

endmodule

/* sim/bus_strobe_props.sv */
/*
  Strobe timing checker for the bus strobe sequencer ports.
  Assumes the nine-cycle external walk and a one-cycle internal answer.
*/
module bus_strobe_props
  import bus_strobe_pkg::*;
(
  input wire logic                  clock,
  input wire logic                  rst,
  input wire logic                  clock_enable,
  input wire logic [7:0]            chip_config_reg,
  input wire logic                  req_valid,
  input wire logic                  req_write,
  input wire logic                  req_external,
  input wire access_kind_type       req_kind,
  input wire logic                  req_ready,
  input wire logic                  done,
  input wire logic [ADDR_WIDTH-1:0] muxed_addr_data_oe_n,
  input wire logic                  read_strobe_n,
  input wire logic                  address_valid_strobe,
  input wire logic                  fetch_kind
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // a request is taken only with ready and enable high
  wire take   = clock_enable && req_ready && req_valid;
  wire ext_rd = take && req_external && !req_write;

  property p_rd; ext_rd |=> read_strobe_n [*3] ##1 !read_strobe_n [*4] ##1 read_strobe_n; endproperty
  a_rd: assert property (p_rd) else $error("read strobe walk wrong");
  property p_wr; take && req_external && req_write |=> read_strobe_n [*8]; endproperty
  a_wr: assert property (p_wr) else $error("read strobe on write");
  property p_int; take && !req_external |=> done && read_strobe_n && !address_valid_strobe; endproperty
  a_int: assert property (p_int) else $error("pin activity on internal access");
  property p_latch;
    take && req_external && chip_config_reg[3] |=> address_valid_strobe [*2] ##1 !address_valid_strobe [*6];
  endproperty
  a_latch: assert property (p_latch) else $error("latch strobe walk wrong");
  // valid strobe stands through the data phase and drops with the done pulse
  property p_valid;
    take && req_external && !chip_config_reg[3] |=> address_valid_strobe [*8] ##1 (!address_valid_strobe && done);
  endproperty
  a_valid: assert property (p_valid) else $error("valid strobe not held to end");
  property p_fki; ext_rd && req_kind == KIND_INSTR |=> fetch_kind [*8]; endproperty
  a_fki: assert property (p_fki) else $error("fetch kind low on fetch");
  property p_fkd; take && req_external && req_kind != KIND_INSTR |=> !fetch_kind [*8]; endproperty
  a_fkd: assert property (p_fkd) else $error("fetch kind high on data");
  // narrow read: upper byte keeps driving the address while the low byte is released
  property p_nar; ext_rd && !chip_config_reg[1] |=> ##5 muxed_addr_data_oe_n == 16'h00FF; endproperty
  a_nar: assert property (p_nar) else $error("narrow cycle pin enables wrong");
  c_latch: cover property (ext_rd && chip_config_reg[3]);
  c_valid: cover property (ext_rd && !chip_config_reg[3]);
  c_int: cover property (take && !req_external);
endmodule

/* sim/ext_mem_model.sv */
/*
  Far-side memory with its address latch; reads return a fixed pattern of the latched address.
  Assumes the lines carry the address on the second strobe cycle.
*/
module ext_mem_model (
  input  wire logic        clock,
  input  wire logic [15:0] lines,
  input  wire logic        read_strobe_n,
  input  wire logic        strobe,
  output logic      [15:0] ad_in
);
  logic [1:0]  sh_q   = 2'b00;
  logic [15:0] addr_q = 16'h0000;
  // capture late in the strobe, after the pin driver lag; works for either strobe mode
  always_ff @(posedge clock) begin
    sh_q <= {sh_q[0], strobe};
    if (strobe && sh_q == 2'b01) addr_q <= lines;
  end
  // released bus shows the inverse so stale data never passes as a match
  assign ad_in = read_strobe_n ? ~(addr_q ^ 16'hC3A5) : addr_q ^ 16'hC3A5;
endmodule

/* sim/external_bus_cycle_strobes_tb_top.sv */
/*
  Self-checking bench of the bus strobe sequencer with the far-side memory model.
  Assumes clock_enable stays high so every access runs its full walk.
*/
module external_bus_cycle_strobes_tb_top
  import bus_strobe_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, rst = 1, clock_enable = 1, req_valid = 0, req_write = 0, req_external = 0;
  logic bus_size_select = 1, req_ready, done, read_strobe_n, address_valid_strobe, fetch_kind;
  logic rd_seen, fk_seen, st_seen;
  logic [15:0] ln_seen;
  logic [7:0] chip_config_reg = 8'h0A;
  logic [15:0] req_addr = 16'h0000, req_wdata = 16'h0000, ad_in, rdata, muxed_addr_data_lines, muxed_addr_data_oe_n;
  access_kind_type req_kind = KIND_DATA;
  int mismatches = 0, n_tests = 0;

  bus_strobe_seq i_bus_strobe_seq (.clock, .rst, .clock_enable, .chip_config_reg, .bus_size_select, .req_valid,
    .req_write, .req_external, .req_kind, .req_addr, .req_wdata, .ad_in, .req_ready, .done, .rdata,
    .muxed_addr_data_lines, .muxed_addr_data_oe_n, .read_strobe_n, .address_valid_strobe, .fetch_kind);
  ext_mem_model i_ext_mem_model (.clock, .lines(muxed_addr_data_lines), .read_strobe_n,
    .strobe(address_valid_strobe), .ad_in);

  initial forever #2 clock = ~clock;

  task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task results;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // one access, entered at a rising edge; strobes are watched at falling edges
  task automatic acc(input logic e, input logic w, input access_kind_type k, input logic [15:0] a);
    int n;
    rd_seen = 0;
    fk_seen = 0;
    st_seen = 0;
    ln_seen = 16'h0000;
    req_valid <= 1'b1;
    req_external <= e;
    req_write <= w;
    req_kind <= k;
    req_addr <= a;
    req_wdata <= ~a;
    @(posedge clock);
    req_valid <= 1'b0;
    for (n = 0; n < 20 && done !== 1'b1; n++) begin
      @(negedge clock);
      rd_seen |= !read_strobe_n;
      fk_seen |= fetch_kind;
      st_seen |= address_valid_strobe;
      if (muxed_addr_data_oe_n[0] === 1'b0) ln_seen = muxed_addr_data_lines;  // last driven word is the data
    end
    chk("done", n < 20, 16'h0001);
    @(posedge clock);
  endtask

  // both strobe modes, wide and narrow, narrow forced once by a cleared enable bit and once by the size pin low
  task automatic t_modes;
    logic [7:0]  cfg [4] = '{8'h0A, 8'h08, 8'h02, 8'h02};
    logic [15:0] adr [4] = '{16'h1234, 16'hABCD, 16'h5E6F, 16'h9087};
    logic [15:0] exp;
    for (int i = 0; i < 4; i++) begin
      chip_config_reg <= cfg[i];
      bus_size_select <= (i != 3);
      repeat (3) @(posedge clock);  // size pin passes its synchroniser
      acc(1'b1, 1'b0, KIND_DATA, adr[i]);
      exp = adr[i] ^ 16'hC3A5;
      if (!(cfg[i][1] && i != 3)) exp[15:8] = 8'h00;
      chk("rdata", rdata, exp);
      chk("strobe", st_seen, 16'h0001);
    end
  endtask

  // every access kind, then a write and an internal access
  task automatic t_kinds;
    for (int k = 0; k < 4; k++) begin
      acc(1'b1, 1'b0, access_kind_type'(k), 16'h4000);
      chk("fetch_kind", fk_seen, k == 0);
      chk("read_seen", rd_seen, 16'h0001);
    end
    acc(1'b1, 1'b1, KIND_INSTR, 16'h0F0F);
    chk("write_rd", rd_seen, 16'h0000);
    chk("write_lines", ln_seen, 16'h0FF0);
    acc(1'b0, 1'b0, KIND_INSTR, 16'h0F0F);
    chk("int_pins", {rd_seen, st_seen, fk_seen}, 16'h0000);
  endtask

  initial begin
    repeat (3) @(posedge clock);
    chk("reset_oe", muxed_addr_data_oe_n, 16'hFFFF);
    chk("reset_ready", req_ready, 16'h0000);
    rst <= 1'b0;
    @(posedge clock);
    t_modes();
    t_kinds();
    results();
  end

  // guard against a hung access
  initial begin
    repeat (2000) @(posedge clock);
    mismatches++;
    results();
  end
endmodule

bind bus_strobe_seq bus_strobe_props i_bus_strobe_props (.clock, .rst, .clock_enable, .chip_config_reg,
  .req_valid, .req_write, .req_external, .req_kind, .req_ready, .done, .muxed_addr_data_oe_n,
  .read_strobe_n, .address_valid_strobe, .fetch_kind);
